// file: core/atpc_pin_ctrl.sv
// Pin-level control and status logic of the audio transceiver.
// Assumes the control-port engine, receiver and transmitter sit on sys_clk.
//
// What this block does
// - Chip-select falling edge selects SPI; otherwise the control port is I2C.
// - I2C address bit 2 from emphasis strap, bits 0 and 1 from pins.
// - Emphasis pin low for 50/15 emphasis, high otherwise.
// - Reset initialises all state but the pin synchronisers and holds the low-power condition.
// - Both line driver outputs are low throughout reset.
// - Recovered master clock is 256x by default, 128x when selected.
// - With PLL bypass and system-clock mode off the master clock pin is an input fed 256Fs.
// - Error pin updates once per sub-frame from seven error sources.
// - Each source maskable; pin shows any unmasked error seen at the last sub-frame.
// - Block-start output high during first sub-frame of each block.
// - Block-start input high three clocks restarts block on next sub-frame.
// - Interrupt polarity and push-pull or open-drain drive are configurable.
// - Interrupt drops only after status read and all status bits zero.
// - User pin is an input after reset, sourcing transmitted user bits.
// - User pin as output makes the user-bit manager the transmit source.
// - System-clock mode forwards the system clock input to master clock pin.
// - Recovered 256x clock is the reference for the clock ratio measurement.
// - Hardware/software strap selects control port or dedicated pins.
// - In I2C the serial data line is open drain only.
// - Mask bit one passes an error to register and pin.
// - Pin user bits move on both edges of the relevant word clock; manager user bits pass every clock.
`timescale 1ns/1ps
`default_nettype none

module atpc_pin_ctrl
  import atpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [SY_NUM-1:0] pinAsync,
  input wire logic ctrlDataBit,
  input wire logic pllBypassSel,
  input wire logic rmck128Sel,
  input wire logic sysClkModeEn,
  input wire logic rxEmph5015,
  input wire logic rxSubframe,
  input wire atpc_rx_err_t rxErr,
  input wire atpc_rx_err_t errMask,
  input wire logic txSubframe,
  input wire logic txBiphase,
  input wire logic tcblIsOutput,
  input wire logic userPinDir,
  input wire logic rxUserBit,
  input wire logic mgrUserBit,
  input wire atpc_int_cfg_t intCfg,
  input wire logic intEvent,
  input wire logic intStatusRead,
  input wire logic intStatusAny,
  output logic ctrlSpiMode,
  output logic ctrlPortEn,
  output logic [2:0] i2cAddr,
  output logic ctrlSerialOut,
  output logic ctrlSerialOe,
  output logic emphasisFlagOut,
  output logic emphasisFlagOe,
  output logic lowPower,
  output logic lineDrvPos,
  output logic lineDrvNeg,
  output logic recoveredMasterClk,
  output logic recoveredMasterClkOe,
  output logic rxErrorOut,
  output atpc_rx_err_t rxErrMasked,
  output logic txBlockStartOut,
  output logic txBlockStartOe,
  output logic userPinOut,
  output logic userPinOe,
  output logic txUserBit,
  output logic intOut,
  output logic intOe,
  output logic [7:0] clkRatio
);

  logic [SY_NUM-1:0] syncA_q;
  logic [SY_NUM-1:0] syncB_q;
  logic [SY_NUM-1:0] syncPrev_q;
  logic strapDone_q;
  logic [8:0] subIdx_q;
  logic [1:0] tcblCnt_q;
  logic restartPend_q;
  logic [6:0] rckCnt_q;
  logic [7:0] omckCnt_q;
  atpc_int_st_t intSt_q;
  logic intLevel;
  logic omckRise;
  logic rckRise;
  logic olrckEdge;
  logic ilrckEdge;

  // First stage feeds only the second stage
  genvar gi;
  generate
    for (gi = 0; gi < SY_NUM; gi++)
    begin : g_sync
      always_ff @(posedge sys_clk)
      begin
        syncA_q[gi] <= pinAsync[gi];
        syncB_q[gi] <= syncA_q[gi];
        syncPrev_q[gi] <= syncB_q[gi];
      end
    end
  endgenerate

  assign omckRise = syncB_q[SY_SYSTEM_CLK_IN] & ~syncPrev_q[SY_SYSTEM_CLK_IN];
  assign rckRise = syncB_q[SY_RCK256] & ~syncPrev_q[SY_RCK256];
  assign olrckEdge = syncB_q[SY_OUT_WORD_CLK] ^ syncPrev_q[SY_OUT_WORD_CLK];
  assign ilrckEdge = syncB_q[SY_IN_WORD_CLK] ^ syncPrev_q[SY_IN_WORD_CLK];

  // Control port protocol; sticky so a later chip-select cannot flip it back
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ctrlSpiMode <= 1'b0;
    else if (syncPrev_q[SY_CS] & ~syncB_q[SY_CS])
      ctrlSpiMode <= 1'b1;
  end

  // Straps caught once after reset release, while emphasis is not yet driven
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      strapDone_q <= 1'b0;
      i2cAddr <= 3'h0;
      ctrlPortEn <= 1'b0;
    end
    else
    begin
      if (!strapDone_q)
      begin
        strapDone_q <= 1'b1;
        i2cAddr[2] <= syncB_q[SY_EMPHASIS_FLAG_OUT];
        ctrlPortEn <= ~syncB_q[SY_HWSW];
      end
      i2cAddr[1] <= syncB_q[SY_AD1];
      i2cAddr[0] <= syncB_q[SY_CS];
    end
  end

  // Serial data: push-pull in SPI, open drain in I2C
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctrlSerialOut <= 1'b0;
      ctrlSerialOe <= 1'b0;
    end
    else if (ctrlSpiMode)
    begin
      ctrlSerialOut <= ctrlDataBit;
      ctrlSerialOe <= ~syncB_q[SY_CS];
    end
    else
    begin
      ctrlSerialOut <= 1'b0;
      ctrlSerialOe <= ~ctrlDataBit;
    end
  end

  // Emphasis pin stays released until the strap has been taken
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      emphasisFlagOut <= 1'b1;
      emphasisFlagOe <= 1'b0;
    end
    else
    begin
      emphasisFlagOut <= ~rxEmph5015;
      emphasisFlagOe <= strapDone_q;
    end
  end

  // Line drivers and low-power indication
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      lineDrvPos <= 1'b0;
      lineDrvNeg <= 1'b0;
      lowPower <= 1'b1;
    end
    else
    begin
      lineDrvPos <= txBiphase;
      lineDrvNeg <= ~txBiphase;
      lowPower <= 1'b0;
    end
  end

  // Master clock pin; only a sampled image of the clocks is routed here
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      recoveredMasterClk <= 1'b0;
      recoveredMasterClkOe <= 1'b0;
    end
    else
    begin
      if (sysClkModeEn)
        recoveredMasterClk <= syncB_q[SY_SYSTEM_CLK_IN];
      else if (rmck128Sel)
        recoveredMasterClk <= syncB_q[SY_RCK128];
      else
        recoveredMasterClk <= syncB_q[SY_RCK256];
      recoveredMasterClkOe <= ~pllBypassSel | sysClkModeEn;
    end
  end

  // Ratio: system clock rises counted over 64 recovered clock rises
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rckCnt_q <= 7'h00;
      omckCnt_q <= 8'h00;
      clkRatio <= 8'h00;
    end
    else
    begin
      if (rckRise)
        rckCnt_q <= (rckCnt_q == RATIO_WINDOW - 7'h01) ? 7'h00
                    : rckCnt_q + 7'h01;
      if (rckRise && rckCnt_q == RATIO_WINDOW - 7'h01)
      begin
        clkRatio <= omckCnt_q;
        omckCnt_q <= {7'h00, omckRise};
      end
      else if (omckRise && omckCnt_q != RATIO_MAX)
        omckCnt_q <= omckCnt_q + 8'h01;
    end
  end

  // Error pin: refreshed at each received sub-frame
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rxErrorOut <= 1'b0;
      rxErrMasked <= '0;
    end
    else if (rxSubframe)
    begin
      rxErrMasked <= rxErr & errMask;
      rxErrorOut <= |(rxErr & errMask);
    end
  end

  // Block-start request: a pulse shorter than three edges is ignored
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tcblCnt_q <= 2'h0;
      restartPend_q <= 1'b0;
    end
    else
    begin
      if (tcblIsOutput || !syncB_q[SY_TX_BLOCK_START])
        tcblCnt_q <= 2'h0;
      else if (tcblCnt_q != TX_BLOCK_START_MIN_EDGES)
        tcblCnt_q <= tcblCnt_q + 2'h1;
      if (!tcblIsOutput && syncB_q[SY_TX_BLOCK_START]
          && tcblCnt_q == TX_BLOCK_START_MIN_EDGES - 2'h1)
        restartPend_q <= 1'b1;
      else if (txSubframe)
        restartPend_q <= 1'b0;
    end
  end

  // Sub-frame index in the transmitted block; first after reset starts one
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      subIdx_q <= CS_BLOCK_LAST;
    else if (txSubframe)
    begin
      if (restartPend_q || subIdx_q == CS_BLOCK_LAST)
        subIdx_q <= CS_BLOCK_FIRST;
      else
        subIdx_q <= subIdx_q + 9'h001;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      txBlockStartOut <= 1'b0;
      txBlockStartOe <= 1'b0;
    end
    else
    begin
      txBlockStartOut <= (subIdx_q == CS_BLOCK_FIRST);
      txBlockStartOe <= tcblIsOutput;
    end
  end

  // User pin and transmitted user bit source
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      userPinOe <= 1'b0;
      userPinOut <= 1'b0;
      txUserBit <= 1'b0;
    end
    else
    begin
      userPinOe <= userPinDir;
      if (userPinDir)
      begin
        if (ilrckEdge)
          userPinOut <= rxUserBit;
        txUserBit <= mgrUserBit;
      end
      else if (olrckEdge)
        txUserBit <= syncB_q[SY_USER];
    end
  end

  // Interrupt: a new event after the status read re-arms the wait for a read
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      intSt_q <= INT_IDLE;
    else
    begin
      case (intSt_q)
        INT_IDLE:
          if (intEvent)
            intSt_q <= INT_ACTIVE;
        INT_ACTIVE:
          if (intStatusRead)
            intSt_q <= INT_READ;
        INT_READ:
          if (intEvent)
            intSt_q <= INT_ACTIVE;
          else if (!intStatusAny)
            intSt_q <= INT_IDLE;
        default:
          intSt_q <= INT_IDLE;
      endcase
    end
  end

  assign intLevel = (intSt_q != INT_IDLE) ~^ intCfg.activeHigh;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      intOut <= 1'b0;
      intOe <= 1'b0;
    end
    else
    begin
      intOut <= intCfg.openDrain ? 1'b0 : intLevel;
      intOe <= intCfg.openDrain ? ~intLevel : 1'b1;
    end
  end

  sequence s_csFall;
    syncPrev_q[SY_CS] && !syncB_q[SY_CS];
  endsequence

  property p_spiSticky;
    @(posedge sys_clk) disable iff (srst)
      s_csFall |=> ctrlSpiMode [*8];
  endproperty
  a_spiSticky: assert property (p_spiSticky)
    else $error("SPI mode not held after chip-select fall");

  property p_i2cOpenDrain;
    @(posedge sys_clk) disable iff (srst)
      !ctrlSpiMode |-> !(ctrlSerialOe && ctrlSerialOut);
  endproperty
  a_i2cOpenDrain: assert property (p_i2cOpenDrain)
    else $error("I2C data line driven high");

  property p_lineLowInReset;
    @(posedge sys_clk) srst |=> !lineDrvPos && !lineDrvNeg;
  endproperty
  a_lineLowInReset: assert property (p_lineLowInReset)
    else $error("Line drivers not low in reset");

  property p_emphasis_flag_out;
    @(posedge sys_clk) disable iff (srst)
      1 |=> emphasisFlagOut == !$past(rxEmph5015);
  endproperty
  a_emphasis_flag_out: assert property (p_emphasis_flag_out)
    else $error("Emphasis pin wrong");

  property p_errPin;
    @(posedge sys_clk) disable iff (srst)
      rxSubframe |=> rxErrorOut == |($past(rxErr) & $past(errMask));
  endproperty
  a_errPin: assert property (p_errPin)
    else $error("Error pin not tracking unmasked errors");

  property p_errHold;
    @(posedge sys_clk) disable iff (srst)
      !rxSubframe |=> $stable(rxErrorOut);
  endproperty
  a_errHold: assert property (p_errHold)
    else $error("Error pin changed between sub-frames");

  sequence s_tcblIdle;
    !syncB_q[SY_TX_BLOCK_START] || tcblIsOutput;
  endsequence

  sequence s_tcblHeld;
    (!tcblIsOutput && syncB_q[SY_TX_BLOCK_START]) [*3];
  endsequence

  // Only the first three held samples arm; a longer hold adds nothing
  property p_tcblArm;
    @(posedge sys_clk) disable iff (srst)
      s_tcblIdle ##1 s_tcblHeld |=> restartPend_q;
  endproperty
  a_tcblArm: assert property (p_tcblArm)
    else $error("Block-start input request not taken");

  property p_tcblRestart;
    @(posedge sys_clk) disable iff (srst)
      restartPend_q && txSubframe |=> subIdx_q == CS_BLOCK_FIRST;
  endproperty
  a_tcblRestart: assert property (p_tcblRestart)
    else $error("Block not restarted after block-start input");

  property p_intHold;
    @(posedge sys_clk) disable iff (srst)
      intSt_q == INT_ACTIVE |=> intSt_q != INT_IDLE;
  endproperty
  a_intHold: assert property (p_intHold)
    else $error("Interrupt dropped before status read");

  property p_userDefault;
    @(posedge sys_clk) srst ##1 !srst && !userPinDir |-> !userPinOe;
  endproperty
  a_userDefault: assert property (p_userDefault)
    else $error("User pin driven after reset");

endmodule : atpc_pin_ctrl

`default_nettype wire

// file: include/atpc_pkg.sv
// Shared constants and carriers for the audio transceiver pin control.
// Assumes a single system clock domain; every pin input is asynchronous.
package atpc_pkg;

  // Receiver error sources, one bit each
  typedef struct packed {
    logic subcode_crc_err;
    logic chan_status_crc_err;
    logic unlock;
    logic validity;
    logic conf;
    logic biphase;
    logic parity;
  } atpc_rx_err_t;

  // Interrupt pin configuration
  typedef struct packed {
    logic activeHigh;
    logic openDrain;
  } atpc_int_cfg_t;

  // Asynchronous pin inputs, index into the synchroniser bank
  localparam int unsigned SY_CS = 0;
  localparam int unsigned SY_AD1 = 1;
  localparam int unsigned SY_EMPHASIS_FLAG_OUT = 2;
  localparam int unsigned SY_HWSW = 3;
  localparam int unsigned SY_SYSTEM_CLK_IN = 4;
  localparam int unsigned SY_TX_BLOCK_START = 5;
  localparam int unsigned SY_USER = 6;
  localparam int unsigned SY_OUT_WORD_CLK = 7;
  localparam int unsigned SY_IN_WORD_CLK = 8;
  localparam int unsigned SY_RCK256 = 9;
  localparam int unsigned SY_RCK128 = 10;
  localparam int unsigned SY_NUM = 11;

  // Sub-frames in one channel status block (192 frames of two)
  localparam logic [8:0] CS_BLOCK_LAST = 9'h17F;
  localparam logic [8:0] CS_BLOCK_FIRST = 9'h000;

  // Least block-start input width, in system clock edges
  localparam logic [1:0] TX_BLOCK_START_MIN_EDGES = 2'h3;

  // Ratio window: 64 recovered clock edges gives 6 fraction bits
  localparam logic [6:0] RATIO_WINDOW = 7'h40;
  localparam logic [7:0] RATIO_MAX = 8'hFF;

  // Interrupt sequencer, Gray coded from IDLE to READ; READ back to IDLE flips both bits
  typedef enum logic [1:0] {
    INT_IDLE = 2'b00,
    INT_ACTIVE = 2'b01,
    INT_READ = 2'b11
  } atpc_int_st_t;

endpackage : atpc_pkg

// file: testbench/atpc_host_model.sv
// Far-side model: system clock source and pulled-up serial data line.
// Assumes the bench wires its outputs to the block's pin inputs.
`timescale 1ns/1ps
`default_nettype none

module atpc_host_model
  import atpc_pkg::*;
(
  input wire logic ctrlSerialOut,
  input wire logic ctrlSerialOe,
  output logic sdaLevel,
  output var logic omckPin
);
  // Runs from time zero; its first edge comes at 62.5 ns, just after reset ends
  initial
  begin
    omckPin = 1'b0;
    forever #62.5 omckPin = ~omckPin;
  end

  // Pull-up wins whenever the device lets go of the line
  assign sdaLevel = ctrlSerialOe ? ctrlSerialOut : 1'b1;
endmodule : atpc_host_model

`default_nettype wire

// file: testbench/atpc_pin_ctrl_bench.sv
// Self-checking bench for the audio transceiver pin control.
// Assumes the host model supplies the system clock pin and data line.
`timescale 1ns/1ps
`default_nettype none

module atpc_pin_ctrl_bench;
  import atpc_pkg::*;
  typedef struct packed {
    atpc_rx_err_t err;
    atpc_rx_err_t mask;
    logic emphasis_flag_out;
    logic expErr;
  } atpc_row_t;
  logic sys_clk, srst, csPin, ad1Pin, emphPin, hwswPin, omckPin, tcblPin;
  logic userPin, out_word_clk, in_word_clk, rck256, rck128, sdaLevel, ctrlDataBit;
  logic pllBypassSel, rmck128Sel, sysClkModeEn, rxEmph5015, rxSubframe;
  logic txSubframe, txBiphase, tcblIsOutput, userPinDir, rxUserBit;
  logic mgrUserBit, intEvent, intStatusRead, intStatusAny, ctrlSpiMode;
  logic ctrlPortEn, ctrlSerialOut, ctrlSerialOe, emphasisFlagOut, lowPower;
  logic emphasisFlagOe, lineDrvPos, lineDrvNeg, recoveredMasterClk;
  logic recoveredMasterClkOe, rxErrorOut, txBlockStartOut, txBlockStartOe;
  logic userPinOut, userPinOe, txUserBit, intOut, intOe;
  logic [2:0] i2cAddr;
  logic [7:0] clkRatio;
  logic [SY_NUM-1:0] pinAsync;
  atpc_rx_err_t rxErr, errMask, rxErrMasked;
  atpc_int_cfg_t intCfg;
  atpc_row_t rows [0:9];
  int fail_count, n_checks;

  assign pinAsync = {rck128, rck256, in_word_clk, out_word_clk, userPin, tcblPin,
                     omckPin, hwswPin, emphPin, ad1Pin, csPin};

  atpc_pin_ctrl dut (.sys_clk, .srst, .pinAsync, .ctrlDataBit,
    .pllBypassSel, .rmck128Sel, .sysClkModeEn, .rxEmph5015, .rxSubframe,
    .rxErr, .errMask, .txSubframe, .txBiphase, .tcblIsOutput, .userPinDir,
    .rxUserBit, .mgrUserBit, .intCfg, .intEvent, .intStatusRead,
    .intStatusAny, .ctrlSpiMode, .ctrlPortEn, .i2cAddr, .ctrlSerialOut,
    .ctrlSerialOe, .emphasisFlagOut, .emphasisFlagOe, .lowPower,
    .lineDrvPos, .lineDrvNeg, .recoveredMasterClk, .recoveredMasterClkOe,
    .rxErrorOut, .rxErrMasked, .txBlockStartOut, .txBlockStartOe,
    .userPinOut, .userPinOe, .txUserBit, .intOut, .intOe, .clkRatio);

  atpc_host_model host (.ctrlSerialOut, .ctrlSerialOe, .sdaLevel, .omckPin);

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Recovered clocks run free; the 256x one also times the ratio window
  always #125 rck256 = ~rck256;
  always #250 rck128 = ~rck128;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // Output only visible in output mode, so input-mode pulses go unchecked
  task automatic txPulse(input logic exp);
    txSubframe = 1'b1;
    tick(1);
    txSubframe = 1'b0;
    tick(2);
    if (tcblIsOutput)
      check(txBlockStartOut, exp);
  endtask : txPulse

  task automatic intPulse();
    intEvent = 1'b1;
    tick(1);
    intEvent = 1'b0;
    tick(3);
  endtask : intPulse

  initial
  begin
    #150000;
    fail_count++;
    summarize();
  end

  initial
  begin
    {csPin, ad1Pin, emphPin, hwswPin, tcblPin, userPin} = 6'h28;
    {out_word_clk, in_word_clk, rck256, rck128, ctrlDataBit, pllBypassSel} = 6'h00;
    {rmck128Sel, sysClkModeEn, rxEmph5015, rxSubframe, txSubframe} = 5'h00;
    {tcblIsOutput, userPinDir, rxUserBit, mgrUserBit, intEvent} = 5'h10;
    {intStatusRead, intStatusAny, txBiphase} = 3'h1;
    rxErr = 7'h00;
    errMask = 7'h00;
    intCfg = 2'h2;
    rows[0] = '{7'h01, 7'h01, 1'b1, 1'b1};
    rows[1] = '{7'h01, 7'h7E, 1'b0, 1'b0};
    rows[2] = '{7'h02, 7'h02, 1'b1, 1'b1};
    rows[3] = '{7'h04, 7'h04, 1'b0, 1'b1};
    rows[4] = '{7'h08, 7'h08, 1'b1, 1'b1};
    rows[5] = '{7'h10, 7'h10, 1'b0, 1'b1};
    rows[6] = '{7'h20, 7'h20, 1'b1, 1'b1};
    rows[7] = '{7'h40, 7'h40, 1'b0, 1'b1};
    rows[8] = '{7'h7F, 7'h00, 1'b1, 1'b0};
    rows[9] = '{7'h00, 7'h7F, 1'b0, 1'b0};
    srst = 1'b1;
    tick(5);
    check(lowPower, 1'b1);
    check({lineDrvPos, lineDrvNeg}, 2'h0);
    tick(1);
    srst = 1'b0;
    tick(3);
    check(lowPower, 1'b0);
    check(ctrlPortEn, 1'b1);
    check(i2cAddr, 3'h5);
    check(emphasisFlagOe, 1'b1);
    check(userPinOe, 1'b0);
    check(recoveredMasterClkOe, 1'b1);
    foreach (rows[i])
    begin
      rxErr = rows[i].err;
      errMask = rows[i].mask;
      rxEmph5015 = rows[i].emphasis_flag_out;
      rxSubframe = 1'b1;
      tick(1);
      rxSubframe = 1'b0;
      tick(2);
      check(rxErrorOut, rows[i].expErr);
      check(rxErrMasked, rows[i].err & rows[i].mask);
      check(emphasisFlagOut, !rows[i].emphasis_flag_out);
    end
    // Errors between sub-frame pulses must not reach the pin
    rxErr = 7'h7F;
    tick(3);
    check(rxErrorOut, 1'b0);
    ctrlDataBit = 1'b1;
    tick(2);
    check({ctrlSerialOut, sdaLevel}, 2'h1);
    ctrlDataBit = 1'b0;
    tick(2);
    check({ctrlSerialOut, sdaLevel}, 2'h0);
    txPulse(1'b1);
    txPulse(1'b0);
    // A one-cycle block-start request is too short and is ignored
    tcblIsOutput = 1'b0;
    tcblPin = 1'b1;
    tick(1);
    tcblPin = 1'b0;
    tick(4);
    tcblIsOutput = 1'b1;
    tick(1);
    txPulse(1'b0);
    tcblIsOutput = 1'b0;
    tcblPin = 1'b1;
    tick(5);
    tcblPin = 1'b0;
    tick(4);
    txPulse(1'b0);
    tcblIsOutput = 1'b1;
    for (int i = 1; i < 384; i++)
      txPulse(1'b0);
    txPulse(1'b1);
    check(txBlockStartOe, 1'b1);
    intPulse();
    check({intOut, intOe}, 2'h3);
    tick(5);
    check(intOut, 1'b1);
    intStatusAny = 1'b1;
    intStatusRead = 1'b1;
    tick(1);
    intStatusRead = 1'b0;
    tick(3);
    check(intOut, 1'b1);
    intStatusAny = 1'b0;
    tick(5);
    check(intOut, 1'b0);
    intCfg = 2'h1;
    tick(3);
    check(intOe, 1'b0);
    intPulse();
    check({intOut, intOe}, 2'h1);
    intStatusRead = 1'b1;
    tick(1);
    intStatusRead = 1'b0;
    tick(6);
    check(intOe, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      userPin = ~userPin;
      out_word_clk = ~out_word_clk;
      tick(6);
      check(txUserBit, userPin);
    end
    userPinDir = 1'b1;
    mgrUserBit = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      rxUserBit = ~rxUserBit;
      in_word_clk = ~in_word_clk;
      tick(6);
      check(userPinOut, rxUserBit);
    end
    check({userPinOe, txUserBit}, 2'h3);
    pllBypassSel = 1'b1;
    rmck128Sel = 1'b1;
    tick(2);
    check(recoveredMasterClkOe, 1'b0);
    sysClkModeEn = 1'b1;
    tick(4000);
    check(recoveredMasterClkOe, 1'b1);
    check(clkRatio >= 8'h7F && clkRatio <= 8'h81, 1'b1);
    csPin = 1'b0;
    tick(5);
    check(ctrlSpiMode, 1'b1);
    csPin = 1'b1;
    tick(5);
    check(ctrlSpiMode, 1'b1);
    srst = 1'b1;
    tick(2);
    check({lowPower, lineDrvPos, lineDrvNeg}, 3'h4);
    srst = 1'b0;
    tick(3);
    check(ctrlSpiMode, 1'b0);
    summarize();
  end
endmodule : atpc_pin_ctrl_bench

`default_nettype wire
